/* design/flash_guard_pkg.sv */
// constants for the block-protection command host
package flash_guard_pkg;
	localparam int ADDR_W = 24;
	localparam int CLK_MHZ = 100;
	localparam int UNLOCK_GAP_US = 1;
	localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * CLK_MHZ;
	localparam int UNLOCK_SETTLE_US = 1;
	localparam int UNLOCK_SETTLE_CYC = UNLOCK_SETTLE_US * CLK_MHZ;
	localparam logic [3:0] SETUP_CYC = 4'h2;
	localparam logic [3:0] WRITE_CYC = 4'h4;
	localparam logic [3:0] READ_CYC = 4'hA;
	localparam logic [3:0] RECOVER_CYC = 4'h2;
	// software register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_PWLO = 4'h2;
	localparam logic [3:0] REG_PWHI = 4'h3;
	localparam logic [3:0] REG_RDLO = 4'h4;
	localparam logic [3:0] REG_RDHI = 4'h5;
	localparam logic [3:0] REG_STAT = 4'h6;
	// flash bus codes
	localparam logic [23:0] UNLK_ADDR1 = 24'h000AAA;
	localparam logic [23:0] UNLK_ADDR2 = 24'h000555;
	localparam logic [7:0] UNLK_DATA1 = 8'hAA;
	localparam logic [7:0] UNLK_DATA2 = 8'h55;
	localparam logic [7:0] CODE_PW_SET = 8'h60;
	localparam logic [7:0] CODE_NV_SET = 8'hC0;
	localparam logic [7:0] CODE_LB_SET = 8'h50;
	localparam logic [7:0] CODE_VOL_SET = 8'hE0;
	localparam logic [7:0] CODE_PROGRAM = 8'hA0;
	localparam logic [7:0] CODE_ERASE = 8'h80;
	localparam logic [7:0] CODE_ERASE_ALL = 8'h30;
	localparam logic [7:0] CODE_EXIT1 = 8'h90;
	localparam logic [7:0] CODE_ZERO = 8'h00;
	localparam logic [7:0] CODE_ONE = 8'h01;
	localparam logic [7:0] CODE_UNLOCK1 = 8'h25;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h03;
	localparam logic [7:0] CODE_UNLOCK_GO = 8'h29;
	localparam logic [7:0] STAT_PROTECTED = 8'h00;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_ENTER_PW = 4'h1, OP_ENTER_NV = 4'h2,
		OP_ENTER_LB = 4'h3, OP_ENTER_VOL = 4'h4, OP_EXIT = 4'h5,
		OP_PW_PROG = 4'h6, OP_PW_READ = 4'h7, OP_PW_UNLOCK = 4'h8,
		OP_NV_PROG = 4'h9, OP_NV_CLEAR = 4'hA, OP_STAT_READ = 4'hB,
		OP_LB_PROG = 4'hC, OP_LB_READ = 4'hD, OP_VOL_PROG = 4'hE,
		OP_VOL_CLEAR = 4'hF
	} op_t;
	typedef enum logic [2:0] {
		SET_READ = 3'h0, SET_PW = 3'h1, SET_NV = 3'h2,
		SET_LB = 3'h3, SET_VOL = 3'h4
	} cmdset_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_GAP = 3'h1, ST_SETUP = 3'h2,
		ST_STROBE = 3'h3, ST_RECOVER = 3'h4, ST_SETTLE = 3'h5
	} state_t;
endpackage

/* design/flash_guard_host.sv */
// host controller issuing flash block-protection command sequences
// Rules from the document
// (RULE1) enter password set: AAA/AA, 555/55, AAA/60 in byte mode
// (RULE2) program password: A0 then byte n at address n, eight times
// (RULE3) after password program, exit before any unlock is issued
// (RULE4) unprogrammed password bits read as one
// (RULE5) password read: eight reads at 00 to 07, then exit; the host does not issue the exit and accepts a password program before it
// (RULE6) password reads give FFh once the password mode lock is set
// (RULE7) unlock: 00/25, 00/03, eight bytes at 00-07, 00/29
// (RULE8) at least 1 us between successive unlock commands
// (RULE9) about 1 us after a good unlock before it completes
// (RULE10) enter non-volatile set: three writes ending in C0
// (RULE11) non-volatile program: x/A0 then block address/00
// (RULE12) status read at block address gives its non-volatile bit
// (RULE13) clear-all x/80, 00/30 erases all; fails when lock bit zero
// (RULE14) enter lock-bit set: three writes ending in 50
// (RULE15) lock-bit program x/A0, x/00 drives lock bit to zero
// (RULE16) lock-bit status read returns the lock bit
// (RULE17) enter volatile set: three writes ending in E0
// (RULE18) volatile program x/A0, block/00 drives its bit to zero
// (RULE19) volatile clear x/A0, block/01 drives its bit to one
// (RULE20) a set non-volatile bit locks the block regardless
// (RULE21) status read at block address gives its volatile bit
// (RULE22) exit leaves any protection set back to Read mode
// (RULE23) exit sequence: x/90 then x/00, needed after every entry
// (RULE24) status reads give 00 protected, 01 unprotected
// (RULE25) upper data byte is don't-care on command cycles
`timescale 1ns/1ps
`default_nettype none
module flash_guard_host (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic [23:0] flashAddr,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic [7:0] dqIn,
	output logic chipEnN,
	output logic outEnN,
	output logic writeEnN,
	output logic byteModeN
);
	typedef struct packed {
		logic isRead;
		logic last;
		logic [23:0] addr;
		logic [7:0] data;
	} step_t;

	function automatic step_t stepOf(input flash_guard_pkg::op_t op,
			input logic [3:0] idx, input logic [63:0] pw,
			input logic [23:0] blk);
		step_t s;
		logic [2:0] n;
		s = '{isRead: 1'b0, last: 1'b0, addr: 24'h000000, data: 8'h00};
		n = idx[3:1];
		case (op)
			flash_guard_pkg::OP_ENTER_PW, flash_guard_pkg::OP_ENTER_NV,
			flash_guard_pkg::OP_ENTER_LB, flash_guard_pkg::OP_ENTER_VOL: begin
				s.last = (idx == 4'h2);
				s.addr = (idx == 4'h1) ? flash_guard_pkg::UNLK_ADDR2
					: flash_guard_pkg::UNLK_ADDR1;
				if (idx == 4'h0) s.data = flash_guard_pkg::UNLK_DATA1;
				else if (idx == 4'h1) s.data = flash_guard_pkg::UNLK_DATA2;
				else if (op == flash_guard_pkg::OP_ENTER_PW)
					s.data = flash_guard_pkg::CODE_PW_SET; // [RULE1]
				else if (op == flash_guard_pkg::OP_ENTER_NV)
					s.data = flash_guard_pkg::CODE_NV_SET; // [RULE10]
				else if (op == flash_guard_pkg::OP_ENTER_LB)
					s.data = flash_guard_pkg::CODE_LB_SET; // [RULE14]
				else
					s.data = flash_guard_pkg::CODE_VOL_SET; // [RULE17]
			end
			flash_guard_pkg::OP_EXIT: begin
				s.last = (idx == 4'h1); // [RULE22]
				s.data = (idx == 4'h0) ? flash_guard_pkg::CODE_EXIT1
					: flash_guard_pkg::CODE_ZERO; // [RULE23]
			end
			flash_guard_pkg::OP_PW_PROG: begin
				s.last = (idx == 4'hF); // [RULE2]
				s.addr = idx[0] ? {21'h0, n} : 24'h000000;
				s.data = idx[0] ? pw[{n, 3'b000} +: 8]
					: flash_guard_pkg::CODE_PROGRAM;
			end
			flash_guard_pkg::OP_PW_READ: begin
				s.isRead = 1'b1;
				s.last = (idx == 4'h7); // [RULE5]
				s.addr = {20'h0, idx};
			end
			flash_guard_pkg::OP_PW_UNLOCK: begin
				s.last = (idx == 4'hA); // [RULE7]
				if (idx == 4'h0) s.data = flash_guard_pkg::CODE_UNLOCK1;
				else if (idx == 4'h1) s.data = flash_guard_pkg::CODE_UNLOCK2;
				else if (idx == 4'hA) s.data = flash_guard_pkg::CODE_UNLOCK_GO;
				else begin
					s.addr = {21'h0, 3'(idx - 4'h2)};
					s.data = pw[{3'(idx - 4'h2), 3'b000} +: 8];
				end
			end
			flash_guard_pkg::OP_STAT_READ, flash_guard_pkg::OP_LB_READ: begin
				s.isRead = 1'b1;
				s.last = 1'b1; // [RULE12] [RULE16] [RULE21]
				s.addr = (op == flash_guard_pkg::OP_STAT_READ) ? blk
					: 24'h000000;
			end
			default: begin
				// two-write commands: program, clear-all, volatile clear
				s.last = (idx == 4'h1);
				if (op == flash_guard_pkg::OP_NV_CLEAR)
					s.data = (idx == 4'h0) ? flash_guard_pkg::CODE_ERASE
						: flash_guard_pkg::CODE_ERASE_ALL; // [RULE13]
				else if (idx == 4'h0)
					s.data = flash_guard_pkg::CODE_PROGRAM;
				else begin
					s.addr = (op == flash_guard_pkg::OP_LB_PROG) ? 24'h000000
						: blk; // [RULE11] [RULE15] [RULE18]
					s.data = (op == flash_guard_pkg::OP_VOL_CLEAR)
						? flash_guard_pkg::CODE_ONE
						: flash_guard_pkg::CODE_ZERO; // [RULE19]
				end
			end
		endcase
		return s;
	endfunction

	function automatic logic allowed(input flash_guard_pkg::op_t op,
			input flash_guard_pkg::cmdset_t set, input logic needExit);
		case (op)
			flash_guard_pkg::OP_ENTER_PW, flash_guard_pkg::OP_ENTER_NV,
			flash_guard_pkg::OP_ENTER_LB, flash_guard_pkg::OP_ENTER_VOL:
				return set == flash_guard_pkg::SET_READ; // [RULE23]
			flash_guard_pkg::OP_EXIT:
				return set != flash_guard_pkg::SET_READ;
			flash_guard_pkg::OP_PW_PROG, flash_guard_pkg::OP_PW_READ:
				return set == flash_guard_pkg::SET_PW;
			flash_guard_pkg::OP_PW_UNLOCK:
				return set == flash_guard_pkg::SET_PW && !needExit; // [RULE3]
			flash_guard_pkg::OP_NV_PROG, flash_guard_pkg::OP_NV_CLEAR:
				return set == flash_guard_pkg::SET_NV;
			flash_guard_pkg::OP_STAT_READ:
				return set == flash_guard_pkg::SET_NV
					|| set == flash_guard_pkg::SET_VOL;
			flash_guard_pkg::OP_LB_PROG, flash_guard_pkg::OP_LB_READ:
				return set == flash_guard_pkg::SET_LB;
			flash_guard_pkg::OP_VOL_PROG, flash_guard_pkg::OP_VOL_CLEAR:
				return set == flash_guard_pkg::SET_VOL;
			default:
				return 1'b0;
		endcase
	endfunction

	flash_guard_pkg::state_t state_q, state_d;
	flash_guard_pkg::op_t op_q, op_d;
	flash_guard_pkg::cmdset_t set_q, set_d;
	logic [3:0] step_q, step_d, phase_q, phase_d;
	logic [7:0] since_q, since_d;
	logic [7:0] settle_q, settle_d;
	logic needExit_q, needExit_d, refused_q, refused_d;
	logic [23:0] blk_q, blk_d;
	logic [63:0] pw_q, pw_d, pwRead_q, pwRead_d;
	logic [7:0] stat_q, stat_d, dqS1_q, dqS2_q;
	logic [31:0] rdata_q, rdata_d;
	logic [23:0] addr_q, addr_d;
	logic [7:0] dqOut_q, dqOut_d;
	logic dqOe_q, dqOe_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d;
	step_t cur;
	logic busy;

	assign cur = stepOf(op_q, step_q, pw_q, blk_q);
	assign busy = (state_q != flash_guard_pkg::ST_IDLE);

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		set_d = set_q;
		step_d = step_q;
		phase_d = phase_q + 4'h1;
		since_d = (since_q == 8'hFF) ? since_q : since_q + 8'h01;
		settle_d = settle_q;
		needExit_d = needExit_q;
		refused_d = refused_q;
		blk_d = blk_q;
		pw_d = pw_q;
		pwRead_d = pwRead_q;
		stat_d = stat_q;
		addr_d = addr_q;
		dqOut_d = dqOut_q;
		dqOe_d = 1'b0;
		ce_d = 1'b1;
		oe_d = 1'b1;
		we_d = 1'b1;
		if (regWr && regAddr == flash_guard_pkg::REG_ADDR)
			blk_d = regWdata[23:0];
		if (!busy && regWr && regAddr == flash_guard_pkg::REG_PWLO)
			pw_d[31:0] = regWdata;
		if (!busy && regWr && regAddr == flash_guard_pkg::REG_PWHI)
			pw_d[63:32] = regWdata;
		case (state_q)
			flash_guard_pkg::ST_IDLE: begin
				if (regWr && regAddr == flash_guard_pkg::REG_CTRL) begin
					op_d = flash_guard_pkg::op_t'(regWdata[3:0]);
					refused_d = !allowed(op_d, set_q, needExit_q);
					step_d = 4'h0;
					phase_d = 4'h0;
					if (!refused_d)
						state_d = flash_guard_pkg::ST_GAP;
				end
			end
			flash_guard_pkg::ST_GAP: begin
				phase_d = 4'h0;
				addr_d = cur.addr;
				// hold back an unlock until 1 us after the previous one has finished settling
				if (op_q != flash_guard_pkg::OP_PW_UNLOCK
						|| since_q >= 8'(flash_guard_pkg::UNLOCK_GAP_CYC))
					state_d = flash_guard_pkg::ST_SETUP; // [RULE8]
			end
			flash_guard_pkg::ST_SETUP: begin
				ce_d = 1'b0;
				addr_d = cur.addr;
				dqOut_d = cur.data; // [RULE25]
				dqOe_d = !cur.isRead;
				if (phase_q == flash_guard_pkg::SETUP_CYC - 4'h1) begin
					phase_d = 4'h0;
					state_d = flash_guard_pkg::ST_STROBE;
					oe_d = !cur.isRead;
					we_d = cur.isRead;
				end
			end
			flash_guard_pkg::ST_STROBE: begin
				ce_d = 1'b0;
				dqOe_d = !cur.isRead;
				oe_d = !cur.isRead;
				we_d = cur.isRead;
				if (phase_q == (cur.isRead ? flash_guard_pkg::READ_CYC
						: flash_guard_pkg::WRITE_CYC) - 4'h1) begin
					phase_d = 4'h0;
					oe_d = 1'b1;
					we_d = 1'b1;
					ce_d = 1'b1;
					state_d = flash_guard_pkg::ST_RECOVER;
					if (op_q == flash_guard_pkg::OP_PW_READ)
						pwRead_d[{step_q[2:0], 3'b000} +: 8] = dqS2_q; // [RULE4] [RULE6]
					else if (cur.isRead)
						stat_d = dqS2_q; // [RULE24] [RULE20]
				end
			end
			flash_guard_pkg::ST_RECOVER: begin
				if (phase_q == flash_guard_pkg::RECOVER_CYC - 4'h1) begin
					phase_d = 4'h0;
					step_d = step_q + 4'h1;
					state_d = flash_guard_pkg::ST_SETUP;
					if (cur.last) begin
						step_d = 4'h0;
						state_d = flash_guard_pkg::ST_IDLE;
						case (op_q)
							flash_guard_pkg::OP_ENTER_PW: set_d = flash_guard_pkg::SET_PW;
							flash_guard_pkg::OP_ENTER_NV: set_d = flash_guard_pkg::SET_NV;
							flash_guard_pkg::OP_ENTER_LB: set_d = flash_guard_pkg::SET_LB;
							flash_guard_pkg::OP_ENTER_VOL: set_d = flash_guard_pkg::SET_VOL;
							flash_guard_pkg::OP_EXIT: begin
								set_d = flash_guard_pkg::SET_READ; // [RULE22]
								needExit_d = 1'b0;
							end
							flash_guard_pkg::OP_PW_PROG: needExit_d = 1'b1; // [RULE3]
							flash_guard_pkg::OP_PW_UNLOCK: begin
								since_d = 8'h00;
								settle_d = 8'h00;
								state_d = flash_guard_pkg::ST_SETTLE;
							end
							default: set_d = set_q;
						endcase
					end
				end
			end
			flash_guard_pkg::ST_SETTLE: begin
				settle_d = settle_q + 8'h01;
				since_d = 8'h00;
				if (settle_q == 8'(flash_guard_pkg::UNLOCK_SETTLE_CYC - 1))
					state_d = flash_guard_pkg::ST_IDLE; // [RULE9]
			end
			default: state_d = flash_guard_pkg::ST_IDLE;
		endcase
		case (regAddr)
			flash_guard_pkg::REG_CTRL:
				rdata_d = {24'h0, set_q, refused_q, needExit_q, 2'b00, busy};
			flash_guard_pkg::REG_ADDR: rdata_d = {8'h00, blk_q};
			flash_guard_pkg::REG_RDLO: rdata_d = pwRead_q[31:0];
			flash_guard_pkg::REG_RDHI: rdata_d = pwRead_q[63:32];
			flash_guard_pkg::REG_STAT:
				rdata_d = {23'h0, stat_q == flash_guard_pkg::STAT_PROTECTED,
					stat_q};
			default: rdata_d = 32'h00000000;
		endcase
		if (!regRd)
			rdata_d = 32'h00000000;
	end

	always_ff @(posedge core_clk) begin
		dqS1_q <= dqIn;
		dqS2_q <= dqS1_q;
		if (!resetn) begin
			state_q <= flash_guard_pkg::ST_IDLE;
			op_q <= flash_guard_pkg::OP_NONE;
			set_q <= flash_guard_pkg::SET_READ;
			step_q <= 4'h0;
			phase_q <= 4'h0;
			since_q <= 8'hFF;
			settle_q <= 8'h00;
			needExit_q <= 1'b0;
			refused_q <= 1'b0;
			blk_q <= 24'h000000;
			pw_q <= 64'hFFFFFFFFFFFFFFFF;
			pwRead_q <= 64'hFFFFFFFFFFFFFFFF;
			stat_q <= 8'h00;
			rdata_q <= 32'h00000000;
			addr_q <= 24'h000000;
			dqOut_q <= 8'h00;
			dqOe_q <= 1'b0;
			ce_q <= 1'b1;
			oe_q <= 1'b1;
			we_q <= 1'b1;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			set_q <= set_d;
			step_q <= step_d;
			phase_q <= phase_d;
			since_q <= since_d;
			settle_q <= settle_d;
			needExit_q <= needExit_d;
			refused_q <= refused_d;
			blk_q <= blk_d;
			pw_q <= pw_d;
			pwRead_q <= pwRead_d;
			stat_q <= stat_d;
			rdata_q <= rdata_d;
			addr_q <= addr_d;
			dqOut_q <= dqOut_d;
			dqOe_q <= dqOe_d;
			ce_q <= ce_d;
			oe_q <= oe_d;
			we_q <= we_d;
		end
	end

	assign regRdata = rdata_q;
	assign flashAddr = addr_q;
	assign dqOut = dqOut_q;
	assign dqOe = dqOe_q;
	assign chipEnN = ce_q;
	assign outEnN = oe_q;
	assign writeEnN = we_q;
	assign byteModeN = 1'b0;

	a_unlock_spacing: assert property (@(posedge core_clk) // [RULE8]
		disable iff (!resetn) (state_q == flash_guard_pkg::ST_GAP
		&& state_d == flash_guard_pkg::ST_SETUP
		&& op_q == flash_guard_pkg::OP_PW_UNLOCK) |-> since_q >= 8'h64)
		else $error("unlock issued too soon after the previous one");
	a_unlock_after_exit: assert property (@(posedge core_clk) // [RULE3]
		disable iff (!resetn) (state_q == flash_guard_pkg::ST_GAP
		&& op_q == flash_guard_pkg::OP_PW_UNLOCK) |-> !needExit_q)
		else $error("unlock issued without exit after password program");
	a_settle_hold: assert property (@(posedge core_clk) // [RULE9]
		disable iff (!resetn) (state_q == flash_guard_pkg::ST_SETTLE
		&& settle_q < 8'h63) |=> busy)
		else $error("unlock settle time cut short");
	a_write_pulse: assert property (@(posedge core_clk) // [RULE25]
		disable iff (!resetn) $fell(writeEnN)
		|-> (!writeEnN && !chipEnN && dqOe)[*4] ##1 writeEnN)
		else $error("write strobe not four cycles");
	a_pw_code: assert property (@(posedge core_clk) // [RULE1]
		disable iff (!resetn) ($fell(writeEnN)
		&& op_q == flash_guard_pkg::OP_ENTER_PW && step_q == 4'h2)
		|-> dqOut == 8'h60 && flashAddr == 24'h000AAA)
		else $error("wrong password set entry code");
	a_exit_code: assert property (@(posedge core_clk) // [RULE23]
		disable iff (!resetn) ($fell(writeEnN)
		&& op_q == flash_guard_pkg::OP_EXIT)
		|-> dqOut == (step_q == 4'h0 ? 8'h90 : 8'h00))
		else $error("wrong exit sequence data");
	a_unlock_go: assert property (@(posedge core_clk) // [RULE7]
		disable iff (!resetn) ($fell(writeEnN)
		&& op_q == flash_guard_pkg::OP_PW_UNLOCK && step_q == 4'hA)
		|-> dqOut == 8'h29 && flashAddr == 24'h000000)
		else $error("unlock not closed by 29");
	a_vol_clear: assert property (@(posedge core_clk) // [RULE19]
		disable iff (!resetn) ($fell(writeEnN)
		&& op_q == flash_guard_pkg::OP_VOL_CLEAR && step_q == 4'h1)
		|-> dqOut == 8'h01 && flashAddr == blk_q)
		else $error("volatile clear data or address wrong");
	a_read_nodrive: assert property (@(posedge core_clk) // [RULE5]
		disable iff (!resetn) !outEnN |-> !dqOe && writeEnN && !chipEnN)
		else $error("bus driven during a read cycle");
	a_exit_returns: assert property (@(posedge core_clk) // [RULE22]
		disable iff (!resetn) (op_q == flash_guard_pkg::OP_EXIT && busy
		##1 !busy) |-> set_q == flash_guard_pkg::SET_READ)
		else $error("exit did not return to read mode");
endmodule
`default_nettype wire

/* verif/flash_guard_model.sv */
// behavioural flash device answering the block-protection command sets
`timescale 1ns/1ps
`default_nettype none
module flash_guard_model (
	input wire logic [23:0] flashAddr,
	input wire logic [7:0] dqOut,
	input wire logic dqOe,
	input wire logic chipEnN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic byteModeN,
	input wire logic pwLocked,
	output logic [7:0] dqBus
);
	logic [7:0] pw [8];
	logic [7:0] tryPw [8];
	logic [127:0] nvBit;
	logic [127:0] volBit;
	logic [127:0] blockLocked;
	logic lockBit;
	logic [2:0] cmdSet;
	logic [1:0] entry;
	logic [7:0] pend;
	logic [7:0] rdVal;
	logic [6:0] blk;
	logic match;
	int tryCnt;
	int tooSoon;
	realtime lastUnl;
	initial begin
		for (int i = 0; i < 8; i++)
			pw[i] = 8'hFF;
		nvBit = '0;
		volBit = '1;
		lockBit = 1'b1;
		cmdSet = 3'h0;
		entry = 2'h0;
		pend = 8'h00;
		tryCnt = 0;
		tooSoon = 0;
		lastUnl = -1.0e6;
	end
	assign blockLocked = nvBit | ~volBit;
	// only address bits 11:0 and block bits 23:17 are decoded
	always @(negedge writeEnN) begin
		if (!chipEnN) begin
			blk = flashAddr[23:17];
			if (cmdSet == 3'h0) begin
				if (flashAddr[11:0] == 12'hAAA && dqOut == 8'hAA)
					entry = 2'h1;
				else if (entry == 2'h1 && flashAddr[11:0] == 12'h555)
					entry = (dqOut == 8'h55) ? 2'h2 : 2'h0;
				else begin
					if (entry == 2'h2 && flashAddr[11:0] == 12'hAAA) begin
						case (dqOut)
							8'h60: cmdSet = 3'h1;
							8'hC0: cmdSet = 3'h2;
							8'h50: cmdSet = 3'h3;
							8'hE0: cmdSet = 3'h4;
							default: cmdSet = 3'h0;
						endcase
					end
					entry = 2'h0;
				end
			end else if (pend == 8'h90) begin
				if (dqOut == 8'h00)
					cmdSet = 3'h0;
				pend = 8'h00;
			end else if (pend == 8'hA0) begin
				case (cmdSet)
					3'h1: pw[flashAddr[2:0]] = pw[flashAddr[2:0]] & dqOut;
					3'h2: nvBit[blk] = nvBit[blk] | lockBit;
					3'h3: lockBit = 1'b0;
					default: volBit[blk] = dqOut[0];
				endcase
				pend = 8'h00;
			end else if (pend == 8'h80) begin
				if (dqOut == 8'h30 && lockBit)
					nvBit = '0;
				pend = 8'h00;
			end else if (pend == 8'h25) begin
				tryCnt = 0;
				pend = (dqOut == 8'h03) ? 8'h03 : 8'h00;
			end else if (pend == 8'h03 && tryCnt < 8) begin
				tryPw[tryCnt] = dqOut;
				tryCnt++;
			end else if (pend == 8'h03) begin
				match = (dqOut == 8'h29);
				for (int i = 0; i < 8; i++)
					match = match & (tryPw[i] == pw[i]);
				if ($realtime - lastUnl < 1000.0)
					tooSoon++;
				else if (match)
					lockBit <= #900 1'b1;
				lastUnl = $realtime;
				pend = 8'h00;
			end else
				pend = dqOut;
		end
	end
	always_comb begin
		case (cmdSet)
			3'h1: rdVal = pwLocked ? 8'hFF : pw[flashAddr[2:0]];
			3'h2: rdVal = {7'h00, ~nvBit[flashAddr[23:17]]};
			3'h3: rdVal = {7'h00, lockBit};
			3'h4: rdVal = {7'h00, volBit[flashAddr[23:17]]};
			default: rdVal = 8'h00;
		endcase
	end
	// a released bus shows the inverse so stale data cannot pass
	assign dqBus = dqOe ? dqOut : ((!chipEnN && !outEnN) ? rdVal : ~rdVal);
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the block-protection command host
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [3:0] CTRL = flash_guard_pkg::REG_CTRL;
	localparam logic [3:0] ADDR = flash_guard_pkg::REG_ADDR;
	localparam logic [3:0] STAT = flash_guard_pkg::REG_STAT;
	localparam logic [63:0] PW = 64'h8877665544332211;
	localparam logic [23:0] BLK5 = 24'h0A0000;
	localparam logic [23:0] BLK3 = 24'h060000;
	logic core_clk;
	logic resetn;
	logic [3:0] regAddr;
	logic [31:0] regWdata;
	logic regWr;
	logic regRd;
	logic [31:0] regRdata;
	logic [23:0] flashAddr;
	logic [7:0] dqOut;
	logic dqOe;
	logic [7:0] dqBus;
	logic chipEnN;
	logic outEnN;
	logic writeEnN;
	logic byteModeN;
	logic pwLocked;
	logic [31:0] rv;
	int nFail;
	int cmpCount;

	flash_guard_host u_dut (.core_clk(core_clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
		.dqOut(dqOut), .dqOe(dqOe), .dqIn(dqBus), .chipEnN(chipEnN),
		.outEnN(outEnN), .writeEnN(writeEnN), .byteModeN(byteModeN));
	flash_guard_model u_model (.flashAddr(flashAddr), .dqOut(dqOut),
		.dqOe(dqOe), .chipEnN(chipEnN), .outEnN(outEnN),
		.writeEnN(writeEnN), .byteModeN(byteModeN), .pwLocked(pwLocked),
		.dqBus(dqBus));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic endOfTest();
		$display("compares %0d mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		rv = regRdata;
	endtask

	// start an operation, wait for busy to drop, check set and refusal
	task automatic op(input logic [3:0] code, input logic [2:0] set,
		input logic refused);
		int n;
		n = 0;
		wr(CTRL, {28'h0, code});
		rd(CTRL);
		while (rv[0] !== 1'b0 && n < 5000) begin
			rd(CTRL);
			n++;
		end
		if (n >= 5000) begin
			nFail++;
			endOfTest();
		end
		chk({28'h0, rv[7:4]}, {28'h0, set, refused});
	endtask

	// run a status-type operation and check the captured byte
	task automatic query(input logic [3:0] code, input logic [23:0] a,
		input logic [2:0] set, input logic [7:0] exp);
		wr(ADDR, {8'h00, a});
		op(code, set, 1'b0);
		rd(STAT);
		chk({23'h0, rv[8:0]}, {23'h0, exp == 8'h00, exp});
	endtask

	initial begin
		resetn = 1'b0;
		regAddr = 4'h0;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		pwLocked = 1'b0;
		nFail = 0;
		cmpCount = 0;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		rd(CTRL);
		chk(rv, 32'h0);
		chk({27'h0, dqOe, byteModeN, chipEnN, outEnN, writeEnN}, 32'h7);
		op(4'h5, 3'h0, 1'b1);
		op(4'h0, 3'h0, 1'b1);
		$display("test reset done");
		op(4'h1, 3'h1, 1'b0);
		op(4'h7, 3'h1, 1'b0);
		rd(flash_guard_pkg::REG_RDLO);
		chk(rv, 32'hFFFFFFFF);
		wr(flash_guard_pkg::REG_PWLO, PW[31:0]);
		wr(flash_guard_pkg::REG_PWHI, PW[63:32]);
		op(4'h6, 3'h1, 1'b0);
		op(4'h8, 3'h1, 1'b1);
		op(4'h7, 3'h1, 1'b0);
		rd(flash_guard_pkg::REG_RDLO);
		chk(rv, PW[31:0]);
		rd(flash_guard_pkg::REG_RDHI);
		chk(rv, PW[63:32]);
		op(4'h5, 3'h0, 1'b0);
		$display("test password done");
		op(4'h3, 3'h3, 1'b0);
		query(4'hD, BLK3, 3'h3, 8'h01);
		op(4'h5, 3'h0, 1'b0);
		op(4'h2, 3'h2, 1'b0);
		wr(ADDR, {8'h00, BLK5});
		op(4'h9, 3'h2, 1'b0);
		query(4'hB, BLK5, 3'h2, 8'h00);
		query(4'hB, BLK3, 3'h2, 8'h01);
		op(4'h5, 3'h0, 1'b0);
		op(4'h3, 3'h3, 1'b0);
		op(4'hC, 3'h3, 1'b0);
		query(4'hD, BLK3, 3'h3, 8'h00);
		op(4'h5, 3'h0, 1'b0);
		op(4'h2, 3'h2, 1'b0);
		op(4'hA, 3'h2, 1'b0);
		query(4'hB, BLK5, 3'h2, 8'h00);
		op(4'h5, 3'h0, 1'b0);
		$display("test non-volatile done");
		wr(flash_guard_pkg::REG_PWLO, ~PW[31:0]);
		op(4'h1, 3'h1, 1'b0);
		op(4'h8, 3'h1, 1'b0);
		wr(flash_guard_pkg::REG_PWLO, PW[31:0]);
		op(4'h8, 3'h1, 1'b0);
		chk(32'(u_model.tooSoon), 32'h0);
		op(4'h5, 3'h0, 1'b0);
		op(4'h3, 3'h3, 1'b0);
		query(4'hD, BLK3, 3'h3, 8'h01);
		op(4'h5, 3'h0, 1'b0);
		op(4'h2, 3'h2, 1'b0);
		op(4'hA, 3'h2, 1'b0);
		query(4'hB, BLK5, 3'h2, 8'h01);
		op(4'h5, 3'h0, 1'b0);
		$display("test unlock done");
		op(4'h4, 3'h4, 1'b0);
		wr(ADDR, {8'h00, BLK3});
		op(4'hE, 3'h4, 1'b0);
		query(4'hB, BLK3, 3'h4, 8'h00);
		op(4'hF, 3'h4, 1'b0);
		query(4'hB, BLK3, 3'h4, 8'h01);
		op(4'h5, 3'h0, 1'b0);
		$display("test volatile done");
		pwLocked <= 1'b1;
		op(4'h1, 3'h1, 1'b0);
		op(4'h7, 3'h1, 1'b0);
		rd(flash_guard_pkg::REG_RDLO);
		chk(rv, 32'hFFFFFFFF);
		op(4'h5, 3'h0, 1'b0);
		$display("test locked read done");
		// reset in the middle of a write strobe must idle the pins
		wr(CTRL, 32'h00000001);
		repeat (4) @(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(CTRL);
		chk(rv, 32'h0);
		chk({27'h0, dqOe, byteModeN, chipEnN, outEnN, writeEnN}, 32'h7);
		$display("test reset in flight done");
		endOfTest();
	end

	initial begin
		#500000;
		nFail++;
		endOfTest();
	end
endmodule
`default_nettype wire
